/* rtl/asc_defines.vh */
/*
 * Constants for the auxiliary converter A sequencer and calibration registers:
 * register offsets, field positions, reset values, mode codes and timing counts.
 * Assumes it is included by bare name from the design file that uses it.
 */
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// Register offsets
`define ASC_ADDR_SEQ_CFG        8'h8C
`define ASC_ADDR_SPARE          8'h8D
`define ASC_ADDR_OCAL           8'h8E
`define ASC_ADDR_CTRL           8'hA0
`define ASC_ADDR_STATUS         8'hA1

// Reset values
`define ASC_RST_SEQ_CFG         16'h0000
`define ASC_RST_SPARE           8'h00
`define ASC_RST_OCAL            16'h0000

// Sequencer configuration fields
`define ASC_MODE_HI             15
`define ASC_MODE_LO             14
`define ASC_DLY_HI              10
`define ASC_DLY_LO              8
`define ASC_OSR_HI              1
`define ASC_OSR_LO              0

// Control and status fields
`define ASC_CTRL_GO_BIT         0
`define ASC_STAT_BUSY_BIT       0
`define ASC_STAT_STEP_LO        1
`define ASC_STAT_CONV_BIT       3

// Sequence start modes
`define ASC_MODE_SINGLE_GO      2'h0
`define ASC_MODE_SINGLE_DRDY    2'h1

// Channel switch delays in modulator clocks
`define ASC_DLY_0               13'h0010
`define ASC_DLY_1               13'h0040
`define ASC_DLY_2               13'h0080
`define ASC_DLY_3               13'h0100
`define ASC_DLY_4               13'h0200
`define ASC_DLY_5               13'h0400
`define ASC_DLY_6               13'h0800
`define ASC_DLY_7               13'h1000

// Conversion times in modulator clocks
`define ASC_CONV_0              13'h0180
`define ASC_CONV_1              13'h0200
`define ASC_CONV_2              13'h0300
`define ASC_CONV_3              13'h0500

// Third order sinc stage ratio
`define ASC_THIRD_ORDER_SINC_RATIO         13'h0040

// Modulator clock divider default
`define ASC_MCLK_DIV            8'h05

`endif

/* rtl/asc_aux_adc_sequencer_config.v */
/*
 * Sequencer configuration, spare byte and offset calibration for auxiliary
 * converter A, with the step sequencer, second decimation stage and offset
 * correction they steer.
 * Assumes all inputs are synchronous to clk_i, that the analog path delivers
 * third order sinc words on third_order_sinc_valid_i, and that enable and power state
 * come from the neighbouring configuration logic.
 */
`timescale 1ns/1ps
`default_nettype none

`include "asc_defines.vh"

// Functional notes
// - Mode 00b: one pass through the sequence per go bit write.
// - Go bit aborts any running sequence and restarts it, in every mode.
// - Mode 01b: single pass starts on data-ready falling edge or go bit.
// - Mode 01b: data-ready edges during a running sequence are ignored.
// - Modes 10b and 11b: sequence repeats continuously after the go bit.
// - Settle delay before each step: 16 to 4096 modulator clocks by code.
// - Ratio code sets total ratio and conversion time 384 to 1280 clocks.
// - Fixed ratio 64 third_order_sinc, then first_order_sinc averaging of 2, 4, 8; none at 00b.
// - Sequencer config bits 13:11 and 7:2 read as zero, ignore writes.
// - Spare byte 7:0 is read/write storage with no effect.
// - Spare register bits 15:8 read as zero.
// - Signed 16-bit offset word, reset zero, corrects conversion results.
// - Offset LSB is 2*Vref/2^16 at gain 1, half that at gain 2 or 4.
// - Disable, standby or power-down clears result and step counter.
module asc_aux_adc_sequencer_config #(
    parameter [7:0] MCLK_DIV  = `ASC_MCLK_DIV,
    parameter [1:0] LAST_STEP = 2'h3
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Register port
    input  wire [7:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output wire [15:0] rdata_o,
    // Converter state from neighbouring logic
    input  wire        aux_converter_enable_i,
    input  wire        standby_i,
    input  wire        power_down_i,
    input  wire [1:0]  aux_gain_setting_i,
    input  wire        primary_data_ready_n_i,
    // Third order sinc words from the analog path
    input  wire [15:0] third_order_sinc_data_i,
    input  wire        third_order_sinc_valid_i,
    // Sequencer outputs
    output wire        mclk_en_o,
    output wire [1:0]  aux_step_counter_o,
    output wire        aux_mux_switch_o,
    output wire        aux_converting_o,
    output wire        aux_seq_busy_o,
    output wire [15:0] aux_result_o,
    output wire        aux_result_valid_o
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_SETTLE = 2'h1;
    localparam [1:0] ST_CONV   = 2'h2;
    localparam [15:0] RST_CFG  = `ASC_RST_SEQ_CFG;

    // Channel switch delay lookup, used for settle length
    function [12:0] dly_cycles;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    dly_cycles = `ASC_DLY_0;
                3'h1:    dly_cycles = `ASC_DLY_1;
                3'h2:    dly_cycles = `ASC_DLY_2;
                3'h3:    dly_cycles = `ASC_DLY_3;
                3'h4:    dly_cycles = `ASC_DLY_4;
                3'h5:    dly_cycles = `ASC_DLY_5;
                3'h6:    dly_cycles = `ASC_DLY_6;
                default: dly_cycles = `ASC_DLY_7;
            endcase
        end
    endfunction

    // Conversion time lookup, used for end of conversion and window start
    function [12:0] conv_cycles;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    conv_cycles = `ASC_CONV_0;
                2'h1:    conv_cycles = `ASC_CONV_1;
                2'h2:    conv_cycles = `ASC_CONV_2;
                default: conv_cycles = `ASC_CONV_3;
            endcase
        end
    endfunction

    // Registers
    reg  [1:0]  mode_q;
    reg  [2:0]  dly_sel_q;
    reg  [1:0]  osr_q;
    reg  [7:0]  spare_q;
    reg  [15:0] ocal_q;
    reg  [15:0] rdata_q;

    // Sequencer state
    reg  [7:0]  div_q;
    reg         drdy_n_q;
    reg  [1:0]  state_q;
    reg  [1:0]  step_q;
    reg  [12:0] cnt_q;
    reg  signed [18:0] acc_q;
    reg  [15:0] result_q;
    reg         result_valid_q;
    reg         mux_switch_q;

    wire        mclk_en;
    wire        conv_off;
    wire        go_wr;
    wire        drdy_fall;
    wire        drdy_start;
    wire        seq_start;
    wire        continuous;
    wire [12:0] dly_len;
    wire [12:0] conv_len;
    wire [12:0] win_start;
    wire        conv_done;

    reg  signed [18:0] avg;
    reg  signed [17:0] off_scaled;
    reg  signed [17:0] corr;
    reg  [15:0] corr_sat;
    reg  [15:0] rd_mux;

    // Modulator clock enable; the whole sequencer counts in these ticks
    assign mclk_en = (div_q == (MCLK_DIV - 8'h01));

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 8'h00;
        end else if (mclk_en) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Register writes
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q    <= RST_CFG[`ASC_MODE_HI:`ASC_MODE_LO];
            dly_sel_q <= RST_CFG[`ASC_DLY_HI:`ASC_DLY_LO];
            osr_q     <= RST_CFG[`ASC_OSR_HI:`ASC_OSR_LO];
            spare_q   <= `ASC_RST_SPARE;
            ocal_q    <= `ASC_RST_OCAL;
        end else if (wr_i) begin
            case (addr_i)
                `ASC_ADDR_SEQ_CFG: begin
                    mode_q    <= wdata_i[`ASC_MODE_HI:`ASC_MODE_LO];
                    dly_sel_q <= wdata_i[`ASC_DLY_HI:`ASC_DLY_LO];
                    osr_q     <= wdata_i[`ASC_OSR_HI:`ASC_OSR_LO];
                end
                `ASC_ADDR_SPARE: begin
                    spare_q <= wdata_i[7:0];
                end
                `ASC_ADDR_OCAL: begin
                    ocal_q <= wdata_i;
                end
                default: begin
                    spare_q <= spare_q;
                end
            endcase
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always @* begin
        rd_mux = 16'h0000;
        case (addr_i)
            `ASC_ADDR_SEQ_CFG: begin
                rd_mux[`ASC_MODE_HI:`ASC_MODE_LO] = mode_q;
                rd_mux[`ASC_DLY_HI:`ASC_DLY_LO]   = dly_sel_q;
                rd_mux[`ASC_OSR_HI:`ASC_OSR_LO]   = osr_q;
            end
            `ASC_ADDR_SPARE: begin
                rd_mux[7:0] = spare_q;
            end
            `ASC_ADDR_OCAL: begin
                rd_mux = ocal_q;
            end
            `ASC_ADDR_STATUS: begin
                rd_mux[`ASC_STAT_BUSY_BIT]                  = (state_q != ST_IDLE);
                rd_mux[`ASC_STAT_STEP_LO+1:`ASC_STAT_STEP_LO] = step_q;
                rd_mux[`ASC_STAT_CONV_BIT]                  = (state_q == ST_CONV);
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 16'h0000;
        end else if (rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // Start sources
    assign conv_off   = ~aux_converter_enable_i | standby_i | power_down_i;
    assign go_wr      = wr_i & (addr_i == `ASC_ADDR_CTRL) & wdata_i[`ASC_CTRL_GO_BIT];
    assign drdy_fall  = drdy_n_q & ~primary_data_ready_n_i;
    assign drdy_start = (mode_q == `ASC_MODE_SINGLE_DRDY) & drdy_fall & (state_q == ST_IDLE);
    assign seq_start  = go_wr | drdy_start;
    assign continuous = mode_q[1];

    assign dly_len   = dly_cycles(dly_sel_q);
    assign conv_len  = conv_cycles(osr_q);
    // First_order_sinc window covers ratio times 64 clocks
    assign win_start = conv_len - (`ASC_THIRD_ORDER_SINC_RATIO << osr_q) - 13'h0001;
    assign conv_done = mclk_en & (cnt_q == conv_len - 13'h0001);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            drdy_n_q <= 1'b1;
        end else begin
            drdy_n_q <= primary_data_ready_n_i;
        end
    end

    // Second stage averaging and offset correction
    always @* begin
        avg = acc_q >>> osr_q;
        // Offset counts double at gain setting codes 2 and 3 (bit 1 set)
        if (aux_gain_setting_i[1]) begin
            off_scaled = {ocal_q[15], ocal_q, 1'b0};
        end else begin
            off_scaled = {{2{ocal_q[15]}}, ocal_q};
        end
        corr = avg[17:0] - off_scaled;
        if (corr > 18'sh07FFF) begin
            corr_sat = 16'h7FFF;
        end else if (corr < -18'sh08000) begin
            corr_sat = 16'h8000;
        end else begin
            corr_sat = corr[15:0];
        end
    end

    // Sequencer
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q        <= ST_IDLE;
            step_q         <= 2'h0;
            cnt_q          <= 13'h0000;
            acc_q          <= 19'sh00000;
            result_q       <= 16'h0000;
            result_valid_q <= 1'b0;
            mux_switch_q   <= 1'b0;
        end else begin
            result_valid_q <= 1'b0;
            mux_switch_q   <= 1'b0;
            if (conv_off) begin
                state_q  <= ST_IDLE;
                step_q   <= 2'h0;
                cnt_q    <= 13'h0000;
                acc_q    <= 19'sh00000;
                result_q <= 16'h0000;
            end else if (seq_start) begin
                state_q      <= ST_SETTLE;
                step_q       <= 2'h0;
                cnt_q        <= 13'h0000;
                mux_switch_q <= 1'b1;
            end else begin
                case (state_q)
                    ST_SETTLE: begin
                        if (mclk_en) begin
                            if (cnt_q == dly_len - 13'h0001) begin
                                state_q <= ST_CONV;
                                cnt_q   <= 13'h0000;
                                acc_q   <= 19'sh00000;
                            end else begin
                                cnt_q <= cnt_q + 13'h0001;
                            end
                        end
                    end
                    ST_CONV: begin
                        // Accumulate last third_order_sinc words
                        // Window sits one tick early: a word in the last tick would miss the result
                        if (third_order_sinc_valid_i && (cnt_q >= win_start) &&
                            (cnt_q != conv_len - 13'h0001)) begin
                            if (osr_q == 2'h0) begin
                                acc_q <= {{3{third_order_sinc_data_i[15]}}, third_order_sinc_data_i};
                            end else begin
                                acc_q <= acc_q + {{3{third_order_sinc_data_i[15]}}, third_order_sinc_data_i};
                            end
                        end
                        if (conv_done) begin
                            result_q       <= corr_sat;
                            result_valid_q <= 1'b1;
                            cnt_q          <= 13'h0000;
                            if (step_q != LAST_STEP) begin
                                step_q       <= step_q + 2'h1;
                                state_q      <= ST_SETTLE;
                                mux_switch_q <= 1'b1;
                            end else if (continuous) begin
                                step_q       <= 2'h0;
                                state_q      <= ST_SETTLE;
                                mux_switch_q <= 1'b1;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else if (mclk_en) begin
                            cnt_q <= cnt_q + 13'h0001;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Outputs
    assign rdata_o            = rdata_q;
    assign mclk_en_o          = mclk_en;
    assign aux_step_counter_o = step_q;
    assign aux_mux_switch_o   = mux_switch_q;
    assign aux_converting_o   = (state_q == ST_CONV);
    assign aux_seq_busy_o     = (state_q != ST_IDLE);
    assign aux_result_o       = result_q;
    assign aux_result_valid_o = result_valid_q;

endmodule

`default_nettype wire

/* testbench/asc_checker_assertions.sv */
/* Assertions for the aux sequencer register block.
   Bound to the design top; timing checks only arm when MCLK_DIV is 1. */
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.vh"
module asc_checker #(
    parameter [7:0] MCLK_DIV = 8'h05
) (
    input wire        clk_i,
    input wire        rst_i,
    input wire [7:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [15:0] rdata_o,
    input wire        aux_converter_enable_i,
    input wire        standby_i,
    input wire        power_down_i,
    input wire        primary_data_ready_n_i,
    input wire [1:0]  aux_step_counter_o,
    input wire        aux_mux_switch_o,
    input wire        aux_converting_o,
    input wire        aux_seq_busy_o,
    input wire [15:0] aux_result_o,
    input wire        aux_result_valid_o
);
    // Shadow of the config word, so timing checks know the codes
    reg  [15:0] cfg_q;
    wire        go_w = wr_i && addr_i == `ASC_ADDR_CTRL && wdata_i[0];
    wire        on_w = aux_converter_enable_i && !standby_i && !power_down_i;
    wire        fast = MCLK_DIV == 8'h01;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= 16'h0000;
        end else if (wr_i && addr_i == `ASC_ADDR_SEQ_CFG) begin
            cfg_q <= wdata_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_cfg_rsvd;
        $past(rd_i) && $past(addr_i) == `ASC_ADDR_SEQ_CFG |-> rdata_o[13:11] == 3'h0
            && rdata_o[7:2] == 6'h00;
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd)
        else $error("reserved config bits not zero");
    property p_spare_hi;
        $past(rd_i) && $past(addr_i) == `ASC_ADDR_SPARE |-> rdata_o[15:8] == 8'h00;
    endproperty
    a_spare_hi: assert property (p_spare_hi)
        else $error("spare upper byte not zero");
    property p_go_start;
        go_w && on_w |=> aux_seq_busy_o && aux_mux_switch_o && aux_step_counter_o == 2'h0;
    endproperty
    a_go_start: assert property (p_go_start)
        else $error("go did not restart at step zero");
    property p_off_idle;
        !on_w |=> !aux_seq_busy_o && aux_step_counter_o == 2'h0 && aux_result_o == 16'h0000;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("converter off but not cleared");
    property p_settle;
        fast && aux_mux_switch_o && cfg_q[10:8] == 3'h0 ##1 aux_seq_busy_o && !go_w
            |-> !aux_converting_o [*8] ##[4:12] aux_converting_o;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settle time wrong");
    property p_conv;
        fast && $rose(aux_converting_o) && cfg_q[1:0] == 2'h0 |-> ##[380:388] aux_result_valid_o;
    endproperty
    a_conv: assert property (p_conv)
        else $error("conversion time wrong");
    property p_cont;
        cfg_q[15] && aux_result_valid_o && on_w |-> aux_seq_busy_o && aux_mux_switch_o;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous sequence stopped");
    property p_drdy_start;
        cfg_q[15:14] == 2'h1 && on_w && !aux_seq_busy_o && $fell(primary_data_ready_n_i)
            |-> ##[1:2] aux_seq_busy_o;
    endproperty
    a_drdy_start: assert property (p_drdy_start)
        else $error("data ready edge did not start");
    property p_drdy_ignore;
        cfg_q[15:14] == 2'h1 && aux_seq_busy_o && $fell(primary_data_ready_n_i) && !go_w
            |=> (!aux_mux_switch_o || aux_result_valid_o) [*2];
    endproperty
    a_drdy_ignore: assert property (p_drdy_ignore)
        else $error("data ready edge restarted a run");
    property p_mode0_stop;
        cfg_q[15:14] == 2'h0 && !aux_seq_busy_o && !go_w |=> !aux_seq_busy_o;
    endproperty
    a_mode0_stop: assert property (p_mode0_stop)
        else $error("single shot started without go");
endmodule
bind asc_aux_adc_sequencer_config asc_checker #(.MCLK_DIV(MCLK_DIV)) asc_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .aux_converter_enable_i(aux_converter_enable_i),
    .standby_i(standby_i), .power_down_i(power_down_i),
    .primary_data_ready_n_i(primary_data_ready_n_i),
    .aux_step_counter_o(aux_step_counter_o), .aux_mux_switch_o(aux_mux_switch_o),
    .aux_converting_o(aux_converting_o), .aux_seq_busy_o(aux_seq_busy_o),
    .aux_result_o(aux_result_o), .aux_result_valid_o(aux_result_valid_o)
);
`default_nettype wire

/* testbench/asc_host_model.sv */
/* Host software model: single-cycle register writes and reads.
   Assumes the bench owns the clock and the converter enable. */
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
    input  wire         clk_i,
    input  wire  [15:0] rdata_i,
    output logic [7:0]  addr_o,
    output logic [15:0] wdata_o,
    output logic        wr_o,
    output logic        rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Idle address and data are inverted so a stale value never looks valid
    task automatic wr_reg(input [7:0] a, input [15:0] d);
        begin
            @(posedge clk_i);
            addr_o <= a;
            wdata_o <= d;
            wr_o <= 1'b1;
            @(posedge clk_i);
            wr_o <= 1'b0;
            addr_o <= ~a;
            wdata_o <= ~d;
        end
    endtask
    task automatic rd_reg(input [7:0] a, output [15:0] d);
        begin
            @(posedge clk_i);
            addr_o <= a;
            rd_o <= 1'b1;
            @(posedge clk_i);
            rd_o <= 1'b0;
            addr_o <= ~a;
            #1 d = rdata_i;
        end
    endtask
endmodule
`default_nettype wire

/* testbench/asc_aux_adc_sequencer_config_tb_top.sv */
/* Bench for the aux sequencer register block: registers, timing, modes.
   Runs the design with MCLK_DIV 1 and two steps per sequence. */
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.vh"
module asc_aux_adc_sequencer_config_tb_top;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         aux_converter_enable_i = 1'b1;
    reg         standby_i = 1'b0;
    reg         power_down_i = 1'b0;
    reg  [1:0]  aux_gain_setting_i = 2'h0;
    reg         primary_data_ready_n_i = 1'b1;
    reg         third_order_sinc_valid_i = 1'b0;
    reg         drdy_run = 1'b0;
    reg  [7:0]  tick_q = 8'h00;
    reg  [15:0] rv;
    wire [7:0]  addr_i;
    wire [15:0] wdata_i;
    wire        wr_i;
    wire        rd_i;
    wire [15:0] rdata_o;
    wire [1:0]  aux_step_counter_o;
    wire        aux_mux_switch_o;
    wire        aux_converting_o;
    wire        aux_seq_busy_o;
    wire [15:0] aux_result_o;
    wire        aux_result_valid_o;
    integer     miscompares = 0;
    integer     n_checks = 0;
    integer     i;
    integer     n;
    always #12.5 clk_i = ~clk_i;
    // One third_order_sinc word every 64 ticks; data-ready falls every 256 cycles
    always @(posedge clk_i) begin
        tick_q <= tick_q + 8'h01;
        third_order_sinc_valid_i <= tick_q[5:0] == 6'h3F;
        primary_data_ready_n_i <= !drdy_run || !tick_q[7];
    end
    asc_host_model asc_host_model_inst (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    asc_aux_adc_sequencer_config #(.MCLK_DIV(8'h01), .LAST_STEP(2'h1))
        asc_aux_adc_sequencer_config_inst (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .aux_converter_enable_i(aux_converter_enable_i),
        .standby_i(standby_i), .power_down_i(power_down_i),
        .aux_gain_setting_i(aux_gain_setting_i),
        .primary_data_ready_n_i(primary_data_ready_n_i), .third_order_sinc_data_i(16'h0100),
        .third_order_sinc_valid_i(third_order_sinc_valid_i), .mclk_en_o(), .aux_step_counter_o(aux_step_counter_o),
        .aux_mux_switch_o(aux_mux_switch_o), .aux_converting_o(aux_converting_o),
        .aux_seq_busy_o(aux_seq_busy_o), .aux_result_o(aux_result_o),
        .aux_result_valid_o(aux_result_valid_o));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chkr(input integer v, input integer e, input integer t);
        begin
            n_checks = n_checks + 1;
            if (v < e - t || v > e + t) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: count %0d not near %0d", $time, v, e);
            end
        end
    endtask
    task wf(input integer s, output integer c);
        reg h;
        begin
            c = 0;
            h = 1'b0;
            while (!h && c < 9000) begin
                @(negedge clk_i);
                c = c + 1;
                h = s == 0 ? aux_mux_switch_o : s == 1 ? aux_converting_o : aux_result_valid_o;
            end
            chk({15'h0000, h}, 16'h0001);
        end
    endtask
    task runs(output integer r);
        integer c;
        begin
            r = 0;
            c = 0;
            @(negedge clk_i);
            while (aux_seq_busy_o === 1'b1 && c < 20000) begin
                @(negedge clk_i);
                c = c + 1;
                r = r + (aux_result_valid_o === 1'b1);
            end
        end
    endtask
    // config is only rewritten with the converter switched off
    task setup(input [15:0] c);
        begin
            @(posedge clk_i);
            aux_converter_enable_i <= 1'b0;
            asc_host_model_inst.wr_reg(`ASC_ADDR_SEQ_CFG, c);
            aux_converter_enable_i <= 1'b1;
        end
    endtask
    task t_regs;
        begin
            @(posedge clk_i);
            aux_converter_enable_i <= 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                asc_host_model_inst.rd_reg(`ASC_ADDR_SEQ_CFG + i[7:0], rv);
                chk(rv, 16'h0000);
                asc_host_model_inst.wr_reg(`ASC_ADDR_SEQ_CFG + i[7:0], 16'hFFFF);
                asc_host_model_inst.rd_reg(`ASC_ADDR_SEQ_CFG + i[7:0], rv);
                chk(rv, i == 0 ? 16'hC703 : i == 1 ? 16'h00FF : 16'hFFFF);
            end
            asc_host_model_inst.rd_reg(8'h55, rv);
            chk(rv, 16'h0000);
            asc_host_model_inst.rd_reg(`ASC_ADDR_CTRL, rv);
            chk(rv, 16'h0000);
            asc_host_model_inst.wr_reg(`ASC_ADDR_SEQ_CFG, 16'h0000);
            asc_host_model_inst.wr_reg(`ASC_ADDR_OCAL, 16'h0010);
            aux_converter_enable_i <= 1'b1;
            $display("regs done");
        end
    endtask
    task t_single;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                @(posedge clk_i);
                aux_gain_setting_i <= {i[0], 1'b0};
                asc_host_model_inst.wr_reg(`ASC_ADDR_CTRL, 16'h0001);
                asc_host_model_inst.rd_reg(`ASC_ADDR_STATUS, rv);
                chk(rv, 16'h0001);
                runs(n);
                chkr(n, 2, 0);
                chk(aux_result_o, i ? 16'h00E0 : 16'h00F0);
            end
            $display("single done");
        end
    endtask
    task t_timing;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                setup({5'h00, i[2:0], 6'h00, i[1:0]});
                asc_host_model_inst.wr_reg(`ASC_ADDR_CTRL, 16'h0001);
                wf(0, n);
                wf(1, n);
                chkr(n, i ? 32 << i : 16, 3);
                wf(2, n);
                chkr(n, i % 4 == 0 ? 384 : i % 4 == 1 ? 512 : i % 4 == 2 ? 768 : 1280, 3);
                runs(n);
            end
            $display("timing done");
        end
    endtask
    task t_cont;
        begin
            for (i = 2; i < 4; i = i + 1) begin
                setup({i[1:0], 6'h01, 8'h00});
                asc_host_model_inst.wr_reg(`ASC_ADDR_CTRL, 16'h0001);
                repeat (3) wf(2, n);
                chk({15'h0000, aux_seq_busy_o}, 16'h0001);
                asc_host_model_inst.wr_reg(`ASC_ADDR_CTRL, 16'h0001);
                @(negedge clk_i);
                chk({13'h0000, aux_mux_switch_o, aux_step_counter_o}, 16'h0004);
                wf(2, n);
                @(posedge clk_i);
                aux_converter_enable_i <= i == 3;
                standby_i <= i == 3;
                repeat (2) @(negedge clk_i);
                chk({aux_seq_busy_o, aux_step_counter_o, aux_result_o[12:0]}, 16'h0000);
                @(posedge clk_i);
                aux_converter_enable_i <= 1'b1;
                standby_i <= 1'b0;
            end
            $display("continuous done");
        end
    endtask
    task t_drdy;
        begin
            setup(16'h4000);
            @(posedge clk_i);
            drdy_run <= 1'b1;
            wf(0, n);
            runs(n);
            chkr(n, 2, 0);
            @(posedge clk_i);
            drdy_run <= 1'b0;
            power_down_i <= 1'b1;
            repeat (2) @(negedge clk_i);
            chk(aux_result_o, 16'h0000);
            @(posedge clk_i);
            power_down_i <= 1'b0;
            $display("data ready done");
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_single;
        t_timing;
        t_cont;
        t_drdy;
        results;
    end
    // About 35k cycles are expected; cut off at 100k
    initial begin
        #2500000;
        miscompares = miscompares + 1;
        $display("mismatch at %0t: watchdog expired", $time);
        results;
    end
endmodule
`default_nettype wire
